// ===== inc/mpr_pkg.sv
// shared constants and carriers for the region programming block
// assumes a 32-bit apb slave with a 12-bit byte address window
package mpr_pkg;

  // ----------------------------------------------------------------
  // sizing
  // ----------------------------------------------------------------
  localparam int         MPR_NUM_REGIONS = 8;
  localparam logic [7:0] MPR_NUM_REG_B   = 8'h08;
  localparam logic       MPR_PRESENT     = 1'b1;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] MPR_OFF_CTRL = 12'h000;
  localparam logic [11:0] MPR_OFF_SEL  = 12'h004;
  localparam logic [11:0] MPR_OFF_BASE = 12'h008;
  localparam logic [11:0] MPR_OFF_ATTR = 12'h00c;
  localparam logic [11:0] MPR_OFF_INFO = 12'h010;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MPR_CTRL_EN_BIT   = 0;
  localparam int MPR_BASE_ADDR_LSB = 8;
  localparam int MPR_BASE_VALID    = 4;
  localparam int MPR_BASE_REG_LSB  = 0;
  localparam int MPR_INFO_CNT_LSB  = 8;
  localparam int MPR_ATTR_XN       = 28;
  localparam int MPR_ATTR_AP_LSB   = 24;
  localparam int MPR_ATTR_TEX_LSB  = 19;
  localparam int MPR_ATTR_S        = 18;
  localparam int MPR_ATTR_C        = 17;
  localparam int MPR_ATTR_B        = 16;
  localparam int MPR_ATTR_SRD_LSB  = 8;
  localparam int MPR_ATTR_SIZE_LSB = 1;
  localparam int MPR_ATTR_EN       = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       MPR_CTRL_RST = 1'b0;
  localparam logic [7:0] MPR_SEL_RST  = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       xn;
    logic [2:0] ap;
    logic [2:0] mem_type_ext_field;
    logic       s;
    logic       c;
    logic       b;
    logic [7:0] subregion_disable_mask;
    logic [4:0] size;
    logic       en;
  } mpr_attr_t;

  typedef struct packed {
    logic [23:0] base;
    mpr_attr_t   attr;
  } mpr_region_t;

endpackage

// ===== logic/mpr_region_view.sv
// effective view of one programmed region for the checking datapath
// assumes cfg comes straight from the register flops
`timescale 1ns/1ps
`default_nettype none
module mpr_region_view (
  input  wire mpr_pkg::mpr_region_t cfg,
  input  wire logic                 glob_en,
  output logic                      region_on,
  output logic                      exec_ok,
  output logic [7:0]                sub_on,
  output logic [31:0]               addr_mask
);

  // region counts only while the whole unit is on
  assign region_on = cfg.attr.en & glob_en;
  // fetch barred from execute-never regions
  assign exec_ok   = region_on & ~cfg.attr.xn;
  // bit k of the mask is the k-th subregion from the bottom
  assign sub_on    = region_on ? ~cfg.attr.subregion_disable_mask : 8'h00;

  // offset bits inside a region of 2^(size+1) bytes; size 31 is all 4gb
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      addr_mask[i] = (5'(i) <= cfg.attr.size) || (i == 0);
    end
  end

endmodule
`default_nettype wire

// ===== logic/mpr_region_regs.sv
// apb register file for region base and attribute programming
// assumes apb3 master, zero-wait answers, one clock pclk
`timescale 1ns/1ps
`default_nettype none
module mpr_region_regs (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output mpr_pkg::mpr_region_t [7:0] region_cfg,
  output logic [7:0]                 region_on,
  output logic [7:0]                 exec_ok,
  output logic [7:0][7:0]            sub_on,
  output logic [7:0][31:0]           addr_mask,
  output logic                       default_map
);

  localparam int N = mpr_pkg::MPR_NUM_REGIONS;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // word compare; whole window reads as unmapped without the unit
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    return mpr_pkg::MPR_PRESENT && (a[11:2] == off[11:2]);
  endfunction

  function automatic logic [31:0] attr_word(input mpr_pkg::mpr_attr_t a);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[mpr_pkg::MPR_ATTR_XN]            = a.xn;
    w[mpr_pkg::MPR_ATTR_AP_LSB +: 3]   = a.ap;
    w[mpr_pkg::MPR_ATTR_TEX_LSB +: 3]  = a.mem_type_ext_field;
    w[mpr_pkg::MPR_ATTR_S]             = a.s;
    w[mpr_pkg::MPR_ATTR_C]             = a.c;
    w[mpr_pkg::MPR_ATTR_B]             = a.b;
    w[mpr_pkg::MPR_ATTR_SRD_LSB +: 8]  = a.subregion_disable_mask;
    w[mpr_pkg::MPR_ATTR_SIZE_LSB +: 5] = a.size;
    w[mpr_pkg::MPR_ATTR_EN]            = a.en;
    return w;
  endfunction

  // unused positions are simply not stored
  function automatic mpr_pkg::mpr_attr_t attr_from(input logic [31:0] w);
    mpr_pkg::mpr_attr_t a;
    a.xn   = w[mpr_pkg::MPR_ATTR_XN];
    a.ap   = w[mpr_pkg::MPR_ATTR_AP_LSB +: 3];
    a.mem_type_ext_field  = w[mpr_pkg::MPR_ATTR_TEX_LSB +: 3];
    a.s    = w[mpr_pkg::MPR_ATTR_S];
    a.c    = w[mpr_pkg::MPR_ATTR_C];
    a.b    = w[mpr_pkg::MPR_ATTR_B];
    a.subregion_disable_mask  = w[mpr_pkg::MPR_ATTR_SRD_LSB +: 8];
    a.size = w[mpr_pkg::MPR_ATTR_SIZE_LSB +: 5];
    a.en   = w[mpr_pkg::MPR_ATTR_EN];
    return a;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                              glob_en_r;
  logic [7:0]                        sel_r;
  mpr_pkg::mpr_region_t [N-1:0]      regions_r;
  logic [31:0]                       prdata_r;
  logic                              pslverr_r;
  logic [31:0]                       rd_nxt;
  logic                              err_nxt;
  logic                              setup;
  logic                              wr;
  logic                              base_valid;
  logic [7:0]                        base_tgt;
  mpr_pkg::mpr_region_t              cur;

  assign setup      = psel & ~penable;
  assign wr         = psel & penable & pwrite;
  assign base_valid = pwdata[mpr_pkg::MPR_BASE_VALID];
  // valid bit names the region directly, else the select register
  assign base_tgt   = base_valid ? {4'h0, pwdata[3:0]} : sel_r;
  // out-of-range selections read as an empty region
  assign cur = (sel_r < mpr_pkg::MPR_NUM_REG_B) ?
               regions_r[sel_r[2:0]] : '0;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // global enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glob_en_r <= mpr_pkg::MPR_CTRL_RST;
    end else if (wr && hit(paddr, mpr_pkg::MPR_OFF_CTRL)) begin
      glob_en_r <= pwdata[mpr_pkg::MPR_CTRL_EN_BIT];
    end
  end

  // select: direct write or copied from a valid base write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= mpr_pkg::MPR_SEL_RST;
    end else if (wr && hit(paddr, mpr_pkg::MPR_OFF_SEL)) begin
      sel_r <= pwdata[7:0];
    end else if (wr && hit(paddr, mpr_pkg::MPR_OFF_BASE) && base_valid) begin
      sel_r <= {4'h0, pwdata[3:0]};
    end
  end

  // per-region storage; an out-of-range target is dropped silently,
  // which is as good as anything for an unpredictable case
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regions_r <= '0;
    end else if (wr) begin
      for (int i = 0; i < N; i++) begin
        if (hit(paddr, mpr_pkg::MPR_OFF_BASE) && base_tgt == 8'(i)) begin
          regions_r[i].base <= pwdata[31:mpr_pkg::MPR_BASE_ADDR_LSB];
        end
        if (hit(paddr, mpr_pkg::MPR_OFF_ATTR) && sel_r == 8'(i)) begin
          regions_r[i].attr <= attr_from(pwdata);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // base bits 7:5 always zero, so ones written there show 256-byte
  // minimum alignment
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (hit(paddr, mpr_pkg::MPR_OFF_CTRL)) begin
      rd_nxt[mpr_pkg::MPR_CTRL_EN_BIT] = glob_en_r;
    end else if (hit(paddr, mpr_pkg::MPR_OFF_SEL)) begin
      rd_nxt[7:0] = sel_r;
    end else if (hit(paddr, mpr_pkg::MPR_OFF_BASE)) begin
      rd_nxt[31:mpr_pkg::MPR_BASE_ADDR_LSB] = cur.base;
      rd_nxt[3:0] = sel_r[3:0];
    end else if (hit(paddr, mpr_pkg::MPR_OFF_ATTR)) begin
      rd_nxt = attr_word(cur.attr);
    end else if (hit(paddr, mpr_pkg::MPR_OFF_INFO)) begin
      rd_nxt[mpr_pkg::MPR_INFO_CNT_LSB +: 8] = mpr_pkg::MPR_NUM_REG_B;
    end else begin
      err_nxt = 1'b1;
    end
  end

  // answer captured in the setup cycle; only bus writes move the
  // registers, so nothing can change before the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= err_nxt;
    end
  end

  assign prdata      = prdata_r;
  assign pslverr     = pslverr_r & psel & penable;
  assign pready      = 1'b1;
  assign default_map = ~glob_en_r;
  assign region_cfg  = regions_r;

  // ----------------------------------------------------------------
  // per-region effective view
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_view
    mpr_region_view u_view (
      .cfg       (regions_r[g]),
      .glob_en   (glob_en_r),
      .region_on (region_on[g]),
      .exec_ok   (exec_ok[g]),
      .sub_on    (sub_on[g]),
      .addr_mask (addr_mask[g])
    );
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_wr_base_valid;
    wr && hit(paddr, mpr_pkg::MPR_OFF_BASE) && base_valid;
  endsequence

  sequence s_rd_base;
    psel && !penable && !pwrite && hit(paddr, mpr_pkg::MPR_OFF_BASE)
    ##1 psel && penable;
  endsequence

  property p_valid_sets_sel;
    @(posedge pclk) disable iff (!presetn)
    s_wr_base_valid |=> sel_r == {4'h0, $past(pwdata[3:0])};
  endproperty
  a_valid_sets_sel: assert property (p_valid_sets_sel)
    else $error("valid base write did not update select");

  property p_base_store;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, mpr_pkg::MPR_OFF_BASE) && base_tgt < 8'h08)
    |=> regions_r[$past(base_tgt[2:0])].base == $past(pwdata[31:8]);
  endproperty
  a_base_store: assert property (p_base_store)
    else $error("base write not stored in target region");

  property p_base_read_sel;
    @(posedge pclk) disable iff (!presetn)
    s_rd_base |-> prdata[3:0] == sel_r[3:0] && prdata[7:4] == 4'h0;
  endproperty
  a_base_read_sel: assert property (p_base_read_sel)
    else $error("base read low bits differ from select");

  property p_align_zero;
    @(posedge pclk) disable iff (!presetn)
    s_rd_base |-> prdata[31:8] == cur.base && prdata[7:5] == 3'h0;
  endproperty
  a_align_zero: assert property (p_align_zero)
    else $error("base readback alignment bits not zero");

  property p_attr_lands;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, mpr_pkg::MPR_OFF_ATTR) && sel_r < 8'h08)
    |=> attr_word(regions_r[$past(sel_r[2:0])].attr)
        == ($past(pwdata) & 32'h173f_ff3f);
  endproperty
  a_attr_lands: assert property (p_attr_lands)
    else $error("attribute write did not reach selected region");

  property p_sel_write;
    @(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, mpr_pkg::MPR_OFF_SEL) |=> sel_r == $past(pwdata[7:0]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select write not taken");

  property p_enable_gate;
    @(posedge pclk) disable iff (!presetn)
    region_on[5] |-> glob_en_r && regions_r[5].attr.en;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("region on without global enable");

  property p_default_map;
    @(posedge pclk) disable iff (!presetn)
    $fell(glob_en_r) |-> default_map && region_on == 8'h00;
  endproperty
  a_default_map: assert property (p_default_map)
    else $error("default map not used after disable");

  property p_xn_fetch;
    @(posedge pclk) disable iff (!presetn)
    regions_r[5].attr.xn |-> !exec_ok[5];
  endproperty
  a_xn_fetch: assert property (p_xn_fetch)
    else $error("fetch allowed from execute-never region");

  property p_sub_order;
    @(posedge pclk) disable iff (!presetn)
    region_on[5] |-> sub_on[5][0] == !regions_r[5].attr.subregion_disable_mask[0]
                  && sub_on[5][7] == !regions_r[5].attr.subregion_disable_mask[7];
  endproperty
  a_sub_order: assert property (p_sub_order)
    else $error("subregion mask order wrong");

  property p_size_mask;
    @(posedge pclk) disable iff (!presetn)
    regions_r[5].attr.size == 5'h07 |->
      addr_mask[5] == 32'h0000_00ff;
  endproperty
  a_size_mask: assert property (p_size_mask)
    else $error("256-byte region mask wrong");

endmodule
`default_nettype wire

// ===== testbench/mpr_region_regs_tb.sv
// self-checking bench for the region base and attribute register block
// assumes the apb slave answers with pready and holds prdata to next setup
`timescale 1ns/1ps
`default_nettype none
module testbench;

  // ----------------------------------------------------------------
  // clock, reset and apb master signals
  // ----------------------------------------------------------------
  logic                       pclk;
  logic                       presetn;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [11:0]                paddr;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  mpr_pkg::mpr_region_t [7:0] region_cfg;
  logic [7:0]                 region_on;
  logic [7:0]                 exec_ok;
  logic [7:0][7:0]            sub_on;
  logic [7:0][31:0]           addr_mask;
  logic                       default_map;
  logic [31:0]                rd;
  logic                       er;
  int                         bad_count;
  int                         cmp_count;

  mpr_region_regs u_mpr_region_regs (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .region_cfg  (region_cfg),
    .region_on   (region_on),
    .exec_ok     (exec_ok),
    .sub_on      (sub_on),
    .addr_mask   (addr_mask),
    .default_map (default_map)
  );

  // 25 mhz clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge; an idle edge
  // follows so the next setup never lands in the same time step
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("[ERR] %0t pready never came", $time);
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset state and presence
    chk({31'h0, default_map}, 32'h0000_0001);
    chk({24'h0, region_on}, 32'h0000_0000);
    rdchk(mpr_pkg::MPR_OFF_INFO, 32'h0000_0800);
    $display("test reset done");
    // ones written to base bits 31:5 read back with low bits cleared
    wr(mpr_pkg::MPR_OFF_SEL, 32'h0000_0003);
    wr(mpr_pkg::MPR_OFF_BASE, 32'hffff_ffe0);
    rdchk(mpr_pkg::MPR_OFF_BASE, 32'hffff_ff03);
    $display("test alignment done");
    // direct region update through the valid bit
    wr(mpr_pkg::MPR_OFF_BASE, 32'h1234_5615);
    rdchk(mpr_pkg::MPR_OFF_SEL, 32'h0000_0005);
    rdchk(mpr_pkg::MPR_OFF_BASE, 32'h1234_5605);
    chk({8'h0, region_cfg[5].base}, 32'h0012_3456);
    chk({8'h0, region_cfg[3].base}, 32'h00ff_ffff);
    $display("test valid write done");
    // attribute fields at fixed spots, reserved bits dropped
    wr(mpr_pkg::MPR_OFF_ATTR, 32'hffff_ffff);
    rdchk(mpr_pkg::MPR_OFF_ATTR, 32'h173f_ff3f);
    chk({31'h0, region_cfg[5].attr.xn}, 32'h0000_0001);
    chk({29'h0, region_cfg[5].attr.ap}, 32'h0000_0007);
    chk({29'h0, region_cfg[5].attr.mem_type_ext_field}, 32'h0000_0007);
    chk({27'h0, region_cfg[5].attr.size}, 32'h0000_001f);
    chk({24'h0, region_on}, 32'h0000_0000);
    chk({31'h0, default_map}, 32'h0000_0001);
    wr(mpr_pkg::MPR_OFF_CTRL, 32'h0000_0001);
    chk({24'h0, region_on}, 32'h0000_0020);
    chk({31'h0, default_map}, 32'h0000_0000);
    chk({24'h0, exec_ok}, 32'h0000_0000);
    $display("test attributes done");
    // subregion mask order and the 256-byte and largest sizes
    wr(mpr_pkg::MPR_OFF_ATTR, 32'h0300_810f);
    chk({24'h0, sub_on[5]}, 32'h0000_007e);
    chk(addr_mask[5], 32'h0000_00ff);
    chk({24'h0, exec_ok}, 32'h0000_0020);
    // a 4gb region needs a base aligned to it, so clear the base first
    wr(mpr_pkg::MPR_OFF_BASE, 32'h0000_0000);
    wr(mpr_pkg::MPR_OFF_ATTR, 32'h0300_813f);
    rdchk(mpr_pkg::MPR_OFF_ATTR, 32'h0300_813f);
    chk(addr_mask[5], 32'hffff_ffff);
    chk({24'h0, sub_on[3]}, 32'h0000_0000);
    $display("test size and mask done");
    // wide select value: base read shows only its low four bits
    wr(mpr_pkg::MPR_OFF_SEL, 32'h0000_0013);
    rdchk(mpr_pkg::MPR_OFF_SEL, 32'h0000_0013);
    rdchk(mpr_pkg::MPR_OFF_BASE, 32'h0000_0003);
    wr(mpr_pkg::MPR_OFF_BASE, 32'habcd_ef12);
    rdchk(mpr_pkg::MPR_OFF_SEL, 32'h0000_0002);
    rdchk(mpr_pkg::MPR_OFF_BASE, 32'habcd_ef02);
    $display("test select done");
    // unmapped word answers with an error and reads zero
    wr(12'h020, 32'hffff_ffff);
    chk({31'h0, er}, 32'h0000_0001);
    xfer(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    rdchk(mpr_pkg::MPR_OFF_CTRL, 32'h0000_0001);
    $display("test unmapped done");
    // turning the unit off falls back to the default map
    wr(mpr_pkg::MPR_OFF_CTRL, 32'h0000_0000);
    chk({31'h0, default_map}, 32'h0000_0001);
    chk({24'h0, region_on}, 32'h0000_0000);
    chk({24'h0, exec_ok}, 32'h0000_0000);
    rdchk(mpr_pkg::MPR_OFF_CTRL, 32'h0000_0000);
    $display("test disable done");
    print_verdict();
  end

endmodule
`default_nettype wire
